// ### test/i2c_bus_partner.sv
// third-party master: claims the bus with a start, frees it with a stop
module i2c_bus_partner (
    input  logic holdBus,
    output logic dataPull,
    output logic clockPull
);
    timeunit 1ns;
    timeprecision 1ps;
    // follows the level, so a release during the claim delay is not lost
    initial begin
        dataPull = 0;
        clockPull = 0;
        forever begin
            wait (holdBus);
            dataPull = 1;
            #500 clockPull = 1;
            wait (!holdBus);
            clockPull = 0;
            #500 dataPull = 0;
        end
    end
endmodule

// ### test/i2c_start_trigger_properties.sv
// concurrent checks on the start-condition trigger ports
module i2c_start_trigger_properties #(
    parameter int HOLD_CYCLES = 4
) (
    input logic                 clk,
    input logic                 rst,
    input logic                 controllerEnable,
    input logic                 reservationDisable,
    input logic                 ctrlWrite,
    input logic                 wrStartTrigger,
    input logic                 wrLeaveCommunication,
    input logic                 dataWrite,
    input logic                 failClear,
    input logic                 arbitrationLost,
    input logic                 dataLineOeN,
    input logic                 clockLineOeN,
    input logic                 startTrigger,
    input logic                 startFailFlag,
    input logic                 startDone,
    input logic                 busBusy,
    input i2c_start_pkg::view_t controlView,
    input i2c_start_pkg::view_t flagView
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire stWr = ctrlWrite && wrStartTrigger && controllerEnable;
    // owning the bus is a repeated start, not a third party
    wire peerBusy = busBusy && dataLineOeN && clockLineOeN;
    a_start_accept: assert property (stWr && !arbitrationLost && !(busBusy && reservationDisable)
        |=> startTrigger) else $error("start write not taken");
    a_fail_busy: assert property (stWr && peerBusy && reservationDisable
        |=> startFailFlag && !startTrigger) else $error("busy bus start not refused");
    a_fail_sticky: assert property (startFailFlag && !failClear |=> startFailFlag)
        else $error("fail flag dropped");
    a_disable_clear: assert property (!controllerEnable |=> !startTrigger)
        else $error("trigger kept while disabled");
    a_event_clear: assert property (!(ctrlWrite && wrStartTrigger) && (arbitrationLost
        || ctrlWrite && wrLeaveCommunication) |=> !startTrigger)
        else $error("trigger kept after abort");
    a_done_pulse: assert property (startDone |=> !startDone && !startTrigger)
        else $error("start done handling wrong");
    a_hold_order: assert property ($fell(dataLineOeN) |-> clockLineOeN [*4])
        else $error("clock line fell too soon");
    a_view_mask: assert property (dataWrite && !ctrlWrite ##1 !ctrlWrite [*2]
        |-> !controlView[1]) else $error("trigger visible after data write");
    a_fail_view: assert property ($rose(startFailFlag) |-> ##[0:2] flagView[7])
        else $error("fail flag not in flag view");
    a_rsv_view: assert property ($stable(reservationDisable) [*4]
        |-> flagView[0] == reservationDisable) else $error("flag view bit 0 wrong");
    cover property (startDone);
    cover property (startFailFlag);
    cover property (stWr && peerBusy && !reservationDisable);
endmodule

bind i2c_start_trigger i2c_start_trigger_properties #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
    .clk, .rst, .controllerEnable, .reservationDisable, .ctrlWrite, .wrStartTrigger,
    .wrLeaveCommunication, .dataWrite, .failClear, .arbitrationLost, .dataLineOeN,
    .clockLineOeN, .startTrigger, .startFailFlag, .startDone, .busBusy, .controlView,
    .flagView
);

// ### test/i2c_start_trigger_tb_top.sv
// bench for the start-condition trigger against a third-party master
module i2c_start_trigger_tb_top import i2c_start_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 4;
    logic clk = 0, linkClk = 0, rst = 1, controllerEnable = 1, reservationDisable = 0;
    logic ctrlWrite = 0, wrStartTrigger = 0, wrStopTrigger = 0, wrAckEnable = 0;
    logic wrLeaveCommunication = 0, dataWrite = 0, failClear = 0, arbitrationLost = 0;
    logic masterWait = 0, addressPhase = 0, extensionCode = 0, slaveAddressMatch = 0;
    logic ninthClock = 0, holdBus = 0;
    logic [4:0] ackTbl [5] = '{5'b10000, 5'b11001, 5'b11100, 5'b01010, 5'b00001};
    wire dataLineOut, dataLineOeN, clockLineOut, clockLineOeN, dPull, cPull;
    wire startTrigger, startFailFlag, startDone, busBusy;
    view_t controlView, flagView;
    int num_errors = 0, comparisons = 0, i, n;
    // pulled-up open-drain lines
    wire dataLineIn = dataLineOeN & ~dPull;
    wire clockLineIn = clockLineOeN & ~cPull;
    wire [3:0] sigs = {busBusy, startDone, clockLineOeN, dataLineOeN};
    always #4 clk = ~clk;
    initial begin
        #3;
        forever #24 linkClk = ~linkClk;
    end
    i2c_start_trigger #(.HOLD_CYCLES(HOLD)) dut_u (.clk, .rst, .ce(1'b1), .linkClk, .dataLineIn,
        .clockLineIn, .dataLineOut, .dataLineOeN, .clockLineOut, .clockLineOeN,
        .controllerEnable, .reservationDisable, .ctrlWrite, .wrStartTrigger, .wrStopTrigger,
        .wrAckEnable, .wrLeaveCommunication, .dataWrite, .failClear, .arbitrationLost,
        .masterWait, .addressPhase, .extensionCode, .slaveAddressMatch, .ninthClock,
        .startTrigger, .startFailFlag, .startDone, .busBusy, .controlView, .flagView);
    i2c_bus_partner peer_u (.holdBus, .dataPull(dPull), .clockPull(cPull));
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input view_t got, input view_t exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic waitSig(input int s, input logic v);
        int k;
        for (k = 0; k < 400 && sigs[s] !== v; k++) @(negedge clk);
        if (k == 400) begin
            chk(sigs[s], v);
            give_verdict;
        end
    endtask
    // software side never writes start with stop, and rewrites a pending start only with the controller off
    task automatic wr(input logic s, input logic p, input logic a, input logic l);
        ctrlWrite = 1;
        {wrStartTrigger, wrStopTrigger, wrAckEnable, wrLeaveCommunication} = {s, p, a, l};
        @(negedge clk);
        ctrlWrite = 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk);
        s = 0;
        @(negedge clk);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (20) @(negedge clk);
        wr(1, 0, 0, 0);
        chk(startTrigger, 1);
        waitSig(0, 0);
        chk(clockLineOeN, 1);
        for (n = 0; n < 400 && clockLineOeN; n++) @(negedge clk);
        chk(n >= HOLD && n < 400, 1);
        if (n == 400) give_verdict;
        chk(startTrigger, 0);
        masterWait = 1;
        wr(1, 0, 0, 0);
        waitSig(1, 1);
        waitSig(2, 1);
        masterWait = 0;
        wr(0, 1, 0, 0);
        waitSig(3, 0);
        holdBus = 1;
        waitSig(3, 1);
        for (i = 0; i < 3; i++) begin
            wr(1, 0, 0, 0);
            chk(startTrigger, 1);
            case (i)
                0: pulse(arbitrationLost);
                1: wr(0, 0, 0, 1);
                default: begin
                    controllerEnable = 0;
                    wr(1, 0, 0, 0);
                end
            endcase
            chk(startTrigger, 0);
            controllerEnable = 1;
        end
        wr(1, 0, 0, 0);
        chk(controlView, 8'h82);
        pulse(dataWrite);
        @(negedge clk);
        chk(controlView, 8'h80);
        chk(dataLineOeN, 1);
        pulse(arbitrationLost);
        reservationDisable = 1;
        wr(1, 0, 0, 0);
        chk({startFailFlag, startTrigger}, 2'b10);
        repeat (5) @(negedge clk);
        chk(flagView, 8'h81);
        pulse(failClear);
        @(negedge clk);
        chk(startFailFlag, 0);
        reservationDisable = 0;
        wr(1, 0, 0, 0);
        holdBus = 0;
        waitSig(2, 1);
        wr(0, 1, 0, 0);
        waitSig(3, 0);
        for (i = 0; i < 5; i++) begin
            wr(0, 0, ackTbl[i][4], 0);
            {addressPhase, extensionCode, slaveAddressMatch, ninthClock} = {ackTbl[i][3:1], 1'b1};
            repeat (40) @(negedge clk);
            chk(dataLineOeN, ackTbl[i][0]);
            ninthClock = 0;
            repeat (40) @(negedge clk);
        end
        chk({dataLineOut, clockLineOut}, 0);
        give_verdict;
    end
endmodule

// ### verilog/i2c_link_pins.sv
// link-clock pin logic: line sampling, bus-busy detection, open-drain drive
module i2c_link_pins (
    input  wire logic   linkClk,
    input  wire logic   rst,
    input  wire logic   ce,
    input  wire logic   dataLineIn,
    input  wire logic   clockLineIn,
    output logic        dataLineOut,
    output logic        dataLineOeN,
    output logic        clockLineOut,
    output logic        clockLineOeN,
    start_link_if.link  lk
);
    logic [1:0] dataSyncFf;
    logic [1:0] clockSyncFf;
    logic [1:0] reqSyncFf [3];
    logic [1:0] ceSyncFf;
    logic       dataPrevFf;
    logic       busyFf;
    logic       dataOeNFf;
    logic       clockOeNFf;

    wire dataNow   = dataSyncFf[1];
    wire clockNow  = clockSyncFf[1];
    wire linkCe    = ceSyncFf[1];
    wire startSeen = clockNow & dataPrevFf & ~dataNow;
    wire stopSeen  = clockNow & ~dataPrevFf & dataNow;
    wire nxt_busy  = startSeen | (busyFf & ~stopSeen);
    // ack low request joins the start drive on the same open-drain line
    wire nxt_driveData  = reqSyncFf[0][1] | reqSyncFf[2][1];
    wire nxt_driveClock = reqSyncFf[1][1];

    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            dataSyncFf  <= 2'b11;
            clockSyncFf <= 2'b11;
            ceSyncFf    <= 2'b00;
            for (int i = 0; i < 3; i++) begin
                reqSyncFf[i] <= 2'b00;
            end
        end else begin
            dataSyncFf  <= {dataSyncFf[0], dataLineIn};
            clockSyncFf <= {clockSyncFf[0], clockLineIn};
            ceSyncFf    <= {ceSyncFf[0], ce};
            reqSyncFf[0] <= {reqSyncFf[0][0], lk.dataLowReq};
            reqSyncFf[1] <= {reqSyncFf[1][0], lk.clockLowReq};
            reqSyncFf[2] <= {reqSyncFf[2][0], lk.ackLowReq};
        end
    end

    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            dataPrevFf   <= 1'b1;
            busyFf       <= 1'b0;
            dataOeNFf    <= 1'b1;
            clockOeNFf   <= 1'b1;
        end else if (linkCe) begin
            dataPrevFf   <= dataNow;
            busyFf       <= nxt_busy;
            dataOeNFf    <= ~nxt_driveData;
            clockOeNFf   <= ~nxt_driveClock;
        end
    end

    assign dataLineOut  = 1'b0;
    assign clockLineOut = 1'b0;
    // enables held inverted in the flop so the pins see no gate after it
    assign dataLineOeN  = dataOeNFf;
    assign clockLineOeN = clockOeNFf;
    assign lk.busBusy   = busyFf;
    assign lk.dataHigh  = dataNow;
    assign lk.clockHigh = clockNow;
endmodule

// ### verilog/i2c_start_map.svh
// constants and layout for the two-wire start-condition trigger
`ifndef I2C_START_MAP_SVH
`define I2C_START_MAP_SVH
`define CTRL_STOP_BIT      0
`define CTRL_START_BIT     1
`define CTRL_ACK_BIT       2
`define CTRL_ENABLE_BIT    7
`define FLAG_RSVDIS_BIT    0
`define FLAG_FAIL_BIT      7
`define CLK_MHZ            125
`define START_HOLD_NS      4000
`define START_HOLD_CYCLES  ((`START_HOLD_NS * `CLK_MHZ + 999) / 1000)
`endif

// ### verilog/i2c_start_pkg.sv
// types shared by the start-condition trigger
package i2c_start_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RELEASE = 3'b001,
        ST_FALL    = 3'b010,
        ST_HOLD    = 3'b011,
        ST_OWN     = 3'b100
    } start_state_e;
    typedef logic [7:0] view_t;
endpackage

// ### verilog/i2c_start_trigger.sv
// start-condition trigger core on the system clock with link-side pin logic
`include "i2c_start_map.svh"
module i2c_start_trigger #(
    parameter int HOLD_CYCLES = `START_HOLD_CYCLES
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          linkClk,
    input  wire logic          dataLineIn,
    input  wire logic          clockLineIn,
    output logic               dataLineOut,
    output logic               dataLineOeN,
    output logic               clockLineOut,
    output logic               clockLineOeN,
    input  wire logic          controllerEnable,
    input  wire logic          reservationDisable,
    input  wire logic          ctrlWrite,
    input  wire logic          wrStartTrigger,
    input  wire logic          wrStopTrigger,
    input  wire logic          wrAckEnable,
    input  wire logic          wrLeaveCommunication,
    input  wire logic          dataWrite,
    input  wire logic          failClear,
    input  wire logic          arbitrationLost,
    input  wire logic          masterWait,
    input  wire logic          addressPhase,
    input  wire logic          extensionCode,
    input  wire logic          slaveAddressMatch,
    input  wire logic          ninthClock,
    output logic               startTrigger,
    output logic               startFailFlag,
    output logic               startDone,
    output logic               busBusy,
    output i2c_start_pkg::view_t controlView,
    output i2c_start_pkg::view_t flagView
);
    import i2c_start_pkg::*;

    localparam int CW = $clog2(HOLD_CYCLES + 1);

    start_link_if lk ();

    i2c_link_pins u_pins (
        .linkClk      (linkClk),
        .rst          (rst),
        .ce           (ce),
        .dataLineIn   (dataLineIn),
        .clockLineIn  (clockLineIn),
        .dataLineOut  (dataLineOut),
        .dataLineOeN  (dataLineOeN),
        .clockLineOut (clockLineOut),
        .clockLineOeN (clockLineOeN),
        .lk           (lk.link)
    );

    // link-side levels cross by two flops each before use
    logic [1:0]   busySyncFf;
    logic [1:0]   dataSyncFf;
    logic [1:0]   clockSyncFf;
    start_state_e stateFf;
    start_state_e nxt_state;
    logic [CW-1:0] holdCntFf;
    logic [CW-1:0] nxt_holdCnt;
    logic         sttFf;
    logic         failFf;
    logic         ackEnFf;
    logic         dataWrittenFf;
    logic         doneFf;
    logic         ackLowFf;
    logic         dataLowFf;
    logic         clockLowFf;
    view_t        controlViewFf;
    view_t        flagViewFf;

    wire busNow    = busySyncFf[1];
    wire dataHi    = dataSyncFf[1];
    wire clockHi   = clockSyncFf[1];
    wire ownsBus   = (stateFf == ST_OWN);
    wire waitState = masterWait | ownsBus;
    // a start write does nothing while the controller is off
    wire startWr   = ctrlWrite & wrStartTrigger & controllerEnable;
    wire thirdBusy = busNow & ~waitState;
    wire refuse    = startWr & thirdBusy & reservationDisable;
    wire acceptSet = startWr & ~refuse;
    wire leaveWr   = ctrlWrite & wrLeaveCommunication;
    wire abortEv   = arbitrationLost | leaveWr | ~controllerEnable;
    wire holdDone  = (holdCntFf == CW'(HOLD_CYCLES));
    wire finishEv  = (stateFf == ST_HOLD) & holdDone;
    wire sttClear  = abortEv | finishEv;
    // a fresh set outweighs a clear landing in the same cycle
    wire nxt_stt   = acceptSet | (sttFf & ~sttClear);
    wire nxt_fail  = refuse | (failFf & ~failClear);
    wire nxt_ackEn = (ctrlWrite & controllerEnable) ? wrAckEnable : ackEnFf;
    wire nxt_dataWritten = dataWrite | (dataWrittenFf & ~ctrlWrite);
    // ack enable only counts outside the address byte, or for an extension code
    wire ackEnEff  = controllerEnable & ackEnFf
                   & (~addressPhase | extensionCode);
    wire slaveAck  = addressPhase & slaveAddressMatch;
    wire nxt_ackLow = controllerEnable & ninthClock
                    & (ackEnEff | slaveAck);

    // next-state and line requests
    always_comb begin
        nxt_state   = stateFf;
        nxt_holdCnt = '0;
        unique case (stateFf)
            ST_IDLE: begin
                if (sttFf & ~abortEv & ~busNow) begin
                    nxt_state = ST_FALL;
                end
            end
            ST_RELEASE: begin
                if (dataHi & clockHi) begin
                    nxt_state = ST_FALL;
                end
            end
            ST_FALL: begin
                if (~dataHi & clockHi) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                nxt_holdCnt = holdCntFf + CW'(1);
                if (holdDone) begin
                    nxt_state = ST_OWN;
                end
            end
            ST_OWN: begin
                if (sttFf) begin
                    nxt_state = ST_RELEASE;
                end else if (ctrlWrite & wrStopTrigger) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (sttFf & masterWait & (stateFf == ST_IDLE)) begin
            nxt_state = ST_RELEASE;
        end
        // abort last, so a wait release never outlives a cleared trigger
        if (abortEv) begin
            nxt_state = ST_IDLE;
        end
    end

    wire nxt_dataLow  = (nxt_state == ST_FALL) | (nxt_state == ST_HOLD)
                      | (nxt_state == ST_OWN);
    // clock is let go during the release so the wait ends
    wire nxt_clockLow = (nxt_state == ST_OWN);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busySyncFf  <= 2'b00;
            dataSyncFf  <= 2'b11;
            clockSyncFf <= 2'b11;
        end else if (ce) begin
            busySyncFf  <= {busySyncFf[0], lk.busBusy};
            dataSyncFf  <= {dataSyncFf[0], lk.dataHigh};
            clockSyncFf <= {clockSyncFf[0], lk.clockHigh};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateFf       <= ST_IDLE;
            holdCntFf     <= '0;
            sttFf         <= 1'b0;
            failFf        <= 1'b0;
            ackEnFf       <= 1'b0;
            dataWrittenFf <= 1'b0;
            doneFf        <= 1'b0;
            ackLowFf      <= 1'b0;
            dataLowFf     <= 1'b0;
            clockLowFf    <= 1'b0;
        end else if (ce) begin
            stateFf       <= nxt_state;
            holdCntFf     <= nxt_holdCnt;
            sttFf         <= nxt_stt;
            failFf        <= nxt_fail;
            ackEnFf       <= nxt_ackEn;
            dataWrittenFf <= nxt_dataWritten;
            doneFf        <= finishEv & ~abortEv;
            ackLowFf      <= nxt_ackLow;
            dataLowFf     <= nxt_dataLow;
            clockLowFf    <= nxt_clockLow;
        end
    end

    // views are registered so software sees settled values
    view_t nxt_controlView;
    view_t nxt_flagView;
    always_comb begin
        nxt_controlView = '0;
        nxt_controlView[`CTRL_ENABLE_BIT] = controllerEnable;
        nxt_controlView[`CTRL_ACK_BIT]    = ackEnFf;
        nxt_controlView[`CTRL_START_BIT]  = sttFf & ~dataWrittenFf;
        nxt_flagView = '0;
        nxt_flagView[`FLAG_FAIL_BIT]      = failFf;
        nxt_flagView[`FLAG_RSVDIS_BIT]    = reservationDisable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            controlViewFf <= '0;
            flagViewFf    <= '0;
        end else if (ce) begin
            controlViewFf <= nxt_controlView;
            flagViewFf    <= nxt_flagView;
        end
    end

    assign lk.dataLowReq  = dataLowFf;
    assign lk.clockLowReq = clockLowFf;
    assign lk.ackLowReq   = ackLowFf;
    assign startTrigger   = sttFf;
    assign startFailFlag  = failFf;
    assign startDone      = doneFf;
    assign busBusy        = busySyncFf[1];
    assign controlView    = controlViewFf;
    assign flagView       = flagViewFf;
endmodule

// ### verilog/start_link_if.sv
// levels passed between the system-clock core and the link-clock pin logic
interface start_link_if;
    logic dataLowReq;
    logic clockLowReq;
    logic ackLowReq;
    logic busBusy;
    logic dataHigh;
    logic clockHigh;
    modport core (output dataLowReq, output clockLowReq, output ackLowReq,
                  input busBusy, input dataHigh, input clockHigh);
    modport link (input dataLowReq, input clockLowReq, input ackLowReq,
                  output busBusy, output dataHigh, output clockHigh);
endinterface
